/* ctcfg_regs.sv */
/*
  Transmitter timing and port configuration register bank with a plain
  strobe port; drives the effective settings to the transmitter datapath.
  Assumes address, data and strobes synchronous to clock_i, and that the
  automatic timing values and strap enables come from the datapath.
*/
// How it works
// - trail override bit selects register trail value
// - exit override bit selects register exit value
// - low-power override bit selects register value
// - alignment bit puts raw pixels high or low
// - port 0 field enables, resets enabled
// - port 1 field enables, resets disabled
// - routing bit 2 drives pin three
// - routing bit 1 drives pin zero, default
// - routing bit 0 reads link-good state
// - two-bit field selects virtual channel
`timescale 1ns/1ns
module ctcfg_regs #(
  parameter int PIX_W = 24,
  parameter int RAW_W = 12
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [ctcfg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ctcfg_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ctcfg_pkg::DATA_W-1:0] rdata_o,
  input wire logic [ctcfg_pkg::TRAIL_W-1:0] auto_trail_i,
  input wire logic [ctcfg_pkg::EXIT_W-1:0] auto_exit_i,
  input wire logic [ctcfg_pkg::LPX_W-1:0] auto_lpx_i,
  input wire logic port0_strap_en_i,
  input wire logic port1_strap_en_i,
  input wire logic link_good_i,
  input wire logic [RAW_W-1:0] raw_pixel_i,
  output logic [ctcfg_pkg::TRAIL_W-1:0] trail_o,
  output logic [ctcfg_pkg::EXIT_W-1:0] exit_o,
  output logic [ctcfg_pkg::LPX_W-1:0] lpx_o,
  output logic [PIX_W-1:0] colour_bus_o,
  output logic port0_en_o,
  output logic port1_en_o,
  output logic general_pin_zero_o,
  output logic general_pin_zero_oe_o,
  output logic general_pin_three_o,
  output logic general_pin_three_oe_o,
  output logic [ctcfg_pkg::VC_W-1:0] virtual_channel_number_o
);
  import ctcfg_pkg::*;

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0] hs_trail_timing;
  logic [7:0] hs_exit_timing;
  logic [7:0] low_power_period_timing;
  logic [7:0] raw_pixel_placement;
  logic [7:0] output_port0_enable;
  logic [7:0] output_port1_enable;
  logic [7:0] link_good_routing;
  logic [7:0] virtual_channel_select;

  // ************************************************************
  // address decode
  // ************************************************************
  // full-width compare, so aliases of the map read as unmapped
  wire hit_trail = (addr_i == HS_TRAIL_TIMING_OFS);
  wire hit_exit = (addr_i == HS_EXIT_TIMING_OFS);
  wire hit_lpx = (addr_i == LOW_POWER_PERIOD_TIMING_OFS);
  wire hit_raw = (addr_i == RAW_PIXEL_PLACEMENT_OFS);
  wire hit_p0 = (addr_i == OUTPUT_PORT0_ENABLE_OFS);
  wire hit_p1 = (addr_i == OUTPUT_PORT1_ENABLE_OFS);
  wire hit_route = (addr_i == LINK_GOOD_ROUTING_OFS);
  wire hit_vc = (addr_i == VIRTUAL_CHANNEL_SELECT_OFS);

  // strobes seen while the enable is low are dropped, not held over
  wire wr_go = wr_i && clk_en_i;
  wire wr_trail = wr_go && hit_trail;
  wire wr_exit = wr_go && hit_exit;
  wire wr_lpx = wr_go && hit_lpx;
  wire wr_raw = wr_go && hit_raw;
  wire wr_p0 = wr_go && hit_p0;
  wire wr_p1 = wr_go && hit_p1;
  wire wr_route = wr_go && hit_route;
  wire wr_vc = wr_go && hit_vc;

  // ************************************************************
  // read selection
  // ************************************************************
  // status bit is live, so the stored copy of bit 0 is never returned
  wire [7:0] route_view = {link_good_routing[DATA_W-1:LINK_GOOD_BIT+1], link_good_i};
  // value for an unmapped offset and for every enabled cycle without a read
  localparam logic [DATA_W-1:0] RDATA_IDLE = '0;
  // unmapped offsets read as zero rather than aliasing a register
  wire [7:0] next_rdata =
    hit_trail ? hs_trail_timing :
    hit_exit ? hs_exit_timing :
    hit_lpx ? low_power_period_timing :
    hit_raw ? raw_pixel_placement :
    hit_p0 ? output_port0_enable :
    hit_p1 ? output_port1_enable :
    hit_route ? route_view :
    hit_vc ? virtual_channel_select :
    RDATA_IDLE;

  // ************************************************************
  // register writes
  // ************************************************************
  // one small process per register; reserved bits are kept and read back as written
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hs_trail_timing <= HS_TRAIL_TIMING_RST;
    end else if (wr_trail) begin
      hs_trail_timing <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hs_exit_timing <= HS_EXIT_TIMING_RST;
    end else if (wr_exit) begin
      hs_exit_timing <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_power_period_timing <= LOW_POWER_PERIOD_TIMING_RST;
    end else if (wr_lpx) begin
      low_power_period_timing <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      raw_pixel_placement <= RAW_PIXEL_PLACEMENT_RST;
    end else if (wr_raw) begin
      raw_pixel_placement <= wdata_i;
    end
  end

  // ************************************************************
  // configuration register writes
  // ************************************************************
  // writes to unmapped offsets match no register and are lost
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_port0_enable <= OUTPUT_PORT0_ENABLE_RST;
    end else if (wr_p0) begin
      output_port0_enable <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      output_port1_enable <= OUTPUT_PORT1_ENABLE_RST;
    end else if (wr_p1) begin
      output_port1_enable <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_good_routing <= LINK_GOOD_ROUTING_RST;
    end else if (wr_route) begin
      link_good_routing <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      virtual_channel_select <= VIRTUAL_CHANNEL_SELECT_RST;
    end else if (wr_vc) begin
      virtual_channel_select <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= RDATA_IDLE;
    end else if (clk_en_i) begin
      // data stands until the next enabled edge only, so a stale read is never taken for a new one
      rdata_o <= rd_i ? next_rdata : RDATA_IDLE;
    end
  end

  // ************************************************************
  // timing override selection
  // ************************************************************
  wire [TRAIL_W-1:0] next_trail;
  wire [EXIT_W-1:0] next_exit;
  wire [LPX_W-1:0] next_lpx;
  wire hs_trail_override = hs_trail_timing[OVERRIDE_BIT];
  wire hs_exit_override = hs_exit_timing[OVERRIDE_BIT];
  wire low_power_period_override = low_power_period_timing[OVERRIDE_BIT];

  ctcfg_sel #(.W(TRAIL_W)) u_trail (
    .override_i(hs_trail_override),
    .reg_val_i(hs_trail_timing[TRAIL_W-1:0]),
    .auto_val_i(auto_trail_i),
    .sel_o(next_trail)
  );
  ctcfg_sel #(.W(EXIT_W)) u_exit (
    .override_i(hs_exit_override),
    .reg_val_i(hs_exit_timing[EXIT_W-1:0]),
    .auto_val_i(auto_exit_i),
    .sel_o(next_exit)
  );
  ctcfg_sel #(.W(LPX_W)) u_lpx (
    .override_i(low_power_period_override),
    .reg_val_i(low_power_period_timing[LPX_W-1:0]),
    .auto_val_i(auto_lpx_i),
    .sel_o(next_lpx)
  );

  // ************************************************************
  // port enables
  // ************************************************************
  wire port0_register_control = output_port0_enable[PORT_RCTL_BIT];
  wire port1_register_control = output_port1_enable[PORT_RCTL_BIT];
  wire [PORT_EN_W-1:0] port0_enable_field = output_port0_enable[PORT_EN_W-1:0];
  wire [PORT_EN_W-1:0] port1_enable_field = output_port1_enable[PORT_EN_W-1:0];
  // partial field codes are undefined; only all-ones counts as enabled
  wire p0_field_on = (port0_enable_field == PORT_EN_ALL);
  wire p1_field_on = (port1_enable_field == PORT_EN_ALL);
  wire next_p0 = port0_register_control ? p0_field_on : port0_strap_en_i;
  wire next_p1 = port1_register_control ? p1_field_on : port1_strap_en_i;

  // ************************************************************
  // raw alignment and link-good routing
  // ************************************************************
  wire raw_msb = raw_pixel_placement[RAW_ALIGN_BIT];
  wire [PIX_W-1:0] raw_low = {{(PIX_W-RAW_W){1'b0}}, raw_pixel_i};
  wire [PIX_W-1:0] raw_high = {raw_pixel_i, {(PIX_W-RAW_W){1'b0}}};
  wire [PIX_W-1:0] next_colour = raw_msb ? raw_high : raw_low;
  wire link_good_to_pin3 = link_good_routing[TO_PIN3_BIT];
  wire link_good_to_pin0 = link_good_routing[TO_PIN0_BIT];
  wire [VC_W-1:0] virtual_channel_number = virtual_channel_select[VC_LSB +: VC_W];

  // ************************************************************
  // registered outputs
  // ************************************************************
  // timing values reach the datapath one edge after the write lands
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trail_o <= '0;
      exit_o <= '0;
      lpx_o <= '0;
    end else if (clk_en_i) begin
      trail_o <= next_trail;
      exit_o <= next_exit;
      lpx_o <= next_lpx;
    end
  end

  // zero fill keeps the unused part of the bus quiet
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      colour_bus_o <= '0;
    end else if (clk_en_i) begin
      colour_bus_o <= next_colour;
    end
  end

  // ************************************************************
  // port, pin and channel outputs
  // ************************************************************
  // strap input governs until software takes control
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port0_en_o <= 1'b0;
      port1_en_o <= 1'b0;
    end else if (clk_en_i) begin
      port0_en_o <= next_p0;
      port1_en_o <= next_p1;
    end
  end

  // both pins may carry the indication at once; a routed pin drives low while the link is bad
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      general_pin_zero_o <= 1'b0;
      general_pin_zero_oe_o <= 1'b0;
      general_pin_three_o <= 1'b0;
      general_pin_three_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      general_pin_zero_o <= link_good_to_pin0 & link_good_i;
      general_pin_zero_oe_o <= link_good_to_pin0;
      general_pin_three_o <= link_good_to_pin3 & link_good_i;
      general_pin_three_oe_o <= link_good_to_pin3;
    end
  end

  // a new channel number applies from the edge after the write lands
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      virtual_channel_number_o <= '0;
    end else if (clk_en_i) begin
      virtual_channel_number_o <= virtual_channel_number;
    end
  end
endmodule : ctcfg_regs

/* ctcfg_pkg.sv */
/*
  Package for the transmitter timing configuration register bank:
  register offsets, field positions, reset values and widths.
  Assumes nothing of its surroundings.
*/
package ctcfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] HS_TRAIL_TIMING_OFS = 8'h06;
  localparam logic [7:0] HS_EXIT_TIMING_OFS = 8'h07;
  localparam logic [7:0] LOW_POWER_PERIOD_TIMING_OFS = 8'h08;
  localparam logic [7:0] RAW_PIXEL_PLACEMENT_OFS = 8'h09;
  localparam logic [7:0] OUTPUT_PORT0_ENABLE_OFS = 8'h13;
  localparam logic [7:0] OUTPUT_PORT1_ENABLE_OFS = 8'h14;
  localparam logic [7:0] LINK_GOOD_ROUTING_OFS = 8'h16;
  localparam logic [7:0] VIRTUAL_CHANNEL_SELECT_OFS = 8'h2E;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] HS_TRAIL_TIMING_RST = 8'h00;
  localparam logic [7:0] HS_EXIT_TIMING_RST = 8'h00;
  localparam logic [7:0] LOW_POWER_PERIOD_TIMING_RST = 8'h00;
  localparam logic [7:0] RAW_PIXEL_PLACEMENT_RST = 8'h00;
  localparam logic [7:0] OUTPUT_PORT0_ENABLE_RST = 8'h3F;
  localparam logic [7:0] OUTPUT_PORT1_ENABLE_RST = 8'h00;
  localparam logic [7:0] LINK_GOOD_ROUTING_RST = 8'h02;
  localparam logic [7:0] VIRTUAL_CHANNEL_SELECT_RST = 8'h00;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int OVERRIDE_BIT = 7;
  localparam int TRAIL_W = 4;
  localparam int EXIT_W = 5;
  localparam int LPX_W = 4;
  localparam int RAW_ALIGN_BIT = 4;
  localparam int PORT_RCTL_BIT = 7;
  localparam int PORT_EN_W = 6;
  localparam logic [5:0] PORT_EN_ALL = 6'h3F;
  localparam logic [5:0] PORT_EN_NONE = 6'h00;
  localparam int TO_PIN3_BIT = 2;
  localparam int TO_PIN0_BIT = 1;
  localparam int LINK_GOOD_BIT = 0;
  localparam int VC_LSB = 6;
  localparam int VC_W = 2;
endpackage : ctcfg_pkg

/* ctcfg_sel.sv */
/*
  Override selector: picks a register value when its override bit is set,
  else the automatically derived value.
  Assumes both inputs are stable in the clock domain of the user.
*/
`timescale 1ns/1ns
module ctcfg_sel #(
  parameter int W = 4
) (
  input wire logic override_i,
  input wire logic [W-1:0] reg_val_i,
  input wire logic [W-1:0] auto_val_i,
  output logic [W-1:0] sel_o
);
  assign sel_o = override_i ? reg_val_i : auto_val_i;
endmodule : ctcfg_sel

/* ctcfg_regs_props.sv */
/* Checker for ctcfg_regs: relations from strobes and inputs to the registered outputs.
   Assumes one clock domain with an active-low asynchronous reset. */
`timescale 1ns/1ns
module ctcfg_regs_props #(
  parameter int PIX_W = 24,
  parameter int RAW_W = 12
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] auto_trail_i,
  input wire logic [4:0] auto_exit_i,
  input wire logic [3:0] auto_lpx_i,
  input wire logic port0_strap_en_i,
  input wire logic port1_strap_en_i,
  input wire logic link_good_i,
  input wire logic [RAW_W-1:0] raw_pixel_i,
  input wire logic [3:0] trail_o,
  input wire logic [4:0] exit_o,
  input wire logic [3:0] lpx_o,
  input wire logic [PIX_W-1:0] colour_bus_o,
  input wire logic port0_en_o,
  input wire logic port1_en_o,
  input wire logic general_pin_zero_o,
  input wire logic general_pin_zero_oe_o,
  input wire logic general_pin_three_o,
  input wire logic general_pin_three_oe_o,
  input wire logic [1:0] virtual_channel_number_o
);
  import ctcfg_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ************************************************************
  // assertions
  // ************************************************************
  // register lands one enabled edge after the strobe, the output one edge later
  sequence wr_to(logic [7:0] a);
    wr_i && clk_en_i && addr_i == a ##1 clk_en_i;
  endsequence
  chk_trail_select: assert property (wr_to(HS_TRAIL_TIMING_OFS) |=>
    trail_o == ($past(wdata_i[7], 2) ? $past(wdata_i[3:0], 2) : $past(auto_trail_i))) else $error("trail wrong");
  chk_exit_select: assert property (wr_to(HS_EXIT_TIMING_OFS) |=>
    exit_o == ($past(wdata_i[7], 2) ? $past(wdata_i[4:0], 2) : $past(auto_exit_i))) else $error("exit wrong");
  chk_lpx_select: assert property (wr_to(LOW_POWER_PERIOD_TIMING_OFS) |=>
    lpx_o == ($past(wdata_i[7], 2) ? $past(wdata_i[3:0], 2) : $past(auto_lpx_i))) else $error("low-power wrong");
  chk_raw_place: assert property (wr_to(RAW_PIXEL_PLACEMENT_OFS) |=> colour_bus_o ==
    ($past(wdata_i[4], 2) ? {$past(raw_pixel_i), {(PIX_W-RAW_W){1'b0}}} : PIX_W'($past(raw_pixel_i))))
    else $error("colour bus wrong");
  chk_port0_sel: assert property (wr_to(OUTPUT_PORT0_ENABLE_OFS) |=> port0_en_o ==
    ($past(wdata_i[7], 2) ? $past(wdata_i[5:0], 2) == PORT_EN_ALL : $past(port0_strap_en_i))) else $error("port0 wrong");
  chk_port1_sel: assert property (wr_to(OUTPUT_PORT1_ENABLE_OFS) |=> port1_en_o ==
    ($past(wdata_i[7], 2) ? $past(wdata_i[5:0], 2) == PORT_EN_ALL : $past(port1_strap_en_i))) else $error("port1 wrong");
  chk_route_oe: assert property (wr_to(LINK_GOOD_ROUTING_OFS) |=> general_pin_three_oe_o == $past(wdata_i[2], 2)
    && general_pin_zero_oe_o == $past(wdata_i[1], 2)) else $error("pin enable wrong");
  chk_pin3_good: assert property ($past(clk_en_i) |->
    general_pin_three_o == (general_pin_three_oe_o && $past(link_good_i))) else $error("pin three wrong");
  chk_pin0_good: assert property ($past(clk_en_i) |->
    general_pin_zero_o == (general_pin_zero_oe_o && $past(link_good_i))) else $error("pin zero wrong");
  chk_status_read: assert property (rd_i && clk_en_i && addr_i == LINK_GOOD_ROUTING_OFS |=>
    rdata_o[0] == $past(link_good_i)) else $error("status bit wrong");
  chk_vc_field: assert property (wr_to(VIRTUAL_CHANNEL_SELECT_OFS) |=>
    virtual_channel_number_o == $past(wdata_i[7:6], 2)) else $error("channel wrong");
endmodule : ctcfg_regs_props

bind ctcfg_regs ctcfg_regs_props #(.PIX_W(PIX_W), .RAW_W(RAW_W)) i_ctcfg_regs_props (.*);

/* ctcfg_regs_bench.sv */
/* Bench for ctcfg_regs: random strobe traffic and datapath inputs against a cycle model.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/1ns
module ctcfg_regs_bench;
  import ctcfg_pkg::*;
  logic clock_i = 1'b0, resetn_i = 1'b0, clk_en_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rnd_en = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, exp_rd;
  logic [3:0] auto_trail_i = 4'h0, auto_lpx_i = 4'h0, trail_o, lpx_o;
  logic [4:0] auto_exit_i = 5'h00, exit_o;
  logic port0_strap_en_i = 1'b0, port1_strap_en_i = 1'b0, link_good_i = 1'b0, port0_en_o, port1_en_o;
  logic general_pin_zero_o, general_pin_zero_oe_o, general_pin_three_o, general_pin_three_oe_o;
  logic [11:0] raw_pixel_i = 12'h000;
  logic [23:0] colour_bus_o;
  logic [1:0] virtual_channel_number_o;
  logic [44:0] exp_out;
  logic [7:0] mdl [256];
  logic [7:0] ofs [10] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h13, 8'h14, 8'h16, 8'h2E, 8'h0A, 8'hF0};
  int err_count = 0;
  int n_checks = 0;
  wire logic [44:0] got = {trail_o, exit_o, lpx_o, colour_bus_o, port0_en_o, port1_en_o, general_pin_zero_o,
    general_pin_zero_oe_o, general_pin_three_o, general_pin_three_oe_o, virtual_channel_number_o};

  ctcfg_regs i_ctcfg_regs (.*);

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk_read(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t read data %h expected %h", $time, g, e);
    end
  endtask : chk_read

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    clk_en_i <= !rnd_en || $urandom_range(7) != 0;
    {auto_trail_i, auto_exit_i, auto_lpx_i, raw_pixel_i, port0_strap_en_i, port1_strap_en_i, link_good_i} <= 28'($urandom);
    @(posedge clock_i);
  endtask : bus

  // ************************************************************
  // cycle model
  // ************************************************************
  // inputs change by NBA, so here they read as the design samples them
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      exp_rd = 8'h00;
      exp_out = '0;
      for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
      mdl[8'h13] = OUTPUT_PORT0_ENABLE_RST;
      mdl[8'h16] = LINK_GOOD_ROUTING_RST;
    end else begin
      chk_read(rdata_o, exp_rd);
      chk(got[44:32], exp_out[44:32]);
      chk(got[31:8], exp_out[31:8]);
      chk(got[7:6], exp_out[7:6]);
      chk(got[5:2], exp_out[5:2]);
      chk(got[1:0], exp_out[1:0]);
      if (clk_en_i) begin
        exp_rd = !rd_i || !(addr_i inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h13, 8'h14, 8'h16, 8'h2E}) ? 8'h00 :
          addr_i == 8'h16 ? {mdl[8'h16][7:1], link_good_i} : mdl[addr_i];
        exp_out = {mdl[6][7] ? mdl[6][3:0] : auto_trail_i, mdl[7][7] ? mdl[7][4:0] : auto_exit_i,
          mdl[8][7] ? mdl[8][3:0] : auto_lpx_i, mdl[9][4] ? {raw_pixel_i, 12'h000} : {12'h000, raw_pixel_i},
          mdl[8'h13][7] ? mdl[8'h13][5:0] == 6'h3F : port0_strap_en_i,
          mdl[8'h14][7] ? mdl[8'h14][5:0] == 6'h3F : port1_strap_en_i,
          mdl[8'h16][1] & link_good_i, mdl[8'h16][1], mdl[8'h16][2] & link_good_i, mdl[8'h16][2], mdl[8'h2E][7:6]};
        if (wr_i) mdl[addr_i] = wdata_i;
      end
    end
  end

  initial begin
    forever #20 clock_i = ~clock_i;
  end

  initial begin
    #200000;
    err_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    void'($urandom(32'h3B60B609));
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (ofs[i]) bus(1'b0, 1'b1, ofs[i], 8'h00);
    $display("test reset_values done");
    for (int v = 0; v < 4; v++) bus(1'b1, 1'b0, 8'h2E, 8'(v << 6) | 8'h15);
    foreach (ofs[i]) bus(1'b1, 1'b0, ofs[i], 8'hBF);
    bus(1'b1, 1'b0, 8'h13, 8'h9E);
    bus(1'b1, 1'b0, 8'h14, 8'h3F);
    bus(1'b1, 1'b0, 8'h16, 8'h06);
    bus(1'b0, 1'b1, 8'h16, 8'h00);
    $display("test directed done");
    rnd_en = 1'b1;
    // mid-run reset shows the defaults come back without a power cycle
    for (int k = 0; k < 1400; k++) begin
      if (k == 700) begin
        resetn_i <= 1'b0;
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        resetn_i <= 1'b1;
      end
      bus(k % 3 == 1, k % 3 == 2, ofs[$urandom_range(9)], 8'($urandom));
    end
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("test random done");
    final_report();
  end
endmodule : ctcfg_regs_bench
